// *** inc/spc_pkg.sv ***
package spc_pkg;

   // ---------------------------------------------
   // Clock and timing
   // ---------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   // Reset release delay after supply is good
   localparam int T_POR_US = 1000;
   localparam int POR_CYCLES = T_POR_US * CYC_PER_US;
   // Undervoltage filter time
   localparam int T_UV_FILT_US = 10;
   localparam int UV_CYCLES = T_UV_FILT_US * CYC_PER_US;

   // ---------------------------------------------
   // Serial word layout
   // ---------------------------------------------
   localparam int WORD_BITS = 16;
   localparam logic [4:0] FRAME_PULSES = 5'h10;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int RSVD_MSB = 11;
   localparam int RSVD_LSB = 8;
   localparam int DATA_MSB = 7;

   // Command targets
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_BSW_CFG = 4'h2;
   localparam logic [3:0] ADDR_R2_CFG = 4'h3;

   // Control register fields
   localparam int CTL_POWER_HOLD = 0;
   localparam int CTL_SENSOR_SUPPLY = 1;
   localparam int CTL_RELAY_TWO = 2;
   localparam int CTL_HS_ON = 3;
   // Battery switch configuration fields
   localparam int BSW_HS_MODE = 0;
   localparam int BSW_DUTY_LSB = 4;
   localparam int PWM_BITS = 4;
   // Relay two configuration fields
   localparam int R2_SDD = 0;

   // Status word fields
   localparam int ST_SPI_ERR = 15;
   localparam int ST_KEY = 14;
   localparam int ST_BSW = 13;
   localparam int ST_POWER_HOLD = 12;
   localparam int FAULT_BITS = 8;

   // Reset values
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BSW_CFG_RESET = 8'h00;
   localparam logic [7:0] R2_CFG_RESET = 8'h00;

endpackage

// *** core/spc_sync.sv ***
module spc_sync
   import spc_pkg::*;
#(
   parameter int W = 1,
   // Flush value; set each bit to its pin's idle level
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } spc_sync_s;

   spc_sync_s st_ff;
   spc_sync_s nxt_st;

   // Two stages; the first feeds only the second
   always_comb begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{s1: RST_VAL, s2: RST_VAL};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.s2;

endmodule

// *** core/spc_reset_gen.sv ***
module spc_reset_gen
   import spc_pkg::*;
#(
   parameter int POR_CYC = POR_CYCLES,
   parameter int UV_CYC = UV_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold,
   input wire logic por_ok,
   input wire logic uv_low,
   output logic mcu_reset_n
);

   localparam int CW = $clog2(POR_CYC + 1);
   localparam int UW = $clog2(UV_CYC + 2);

   typedef enum logic [1:0] {RG_HOLD, RG_DELAY, RG_RUN} spc_rg_e;
   typedef struct packed {
      spc_rg_e state;
      logic [CW-1:0] cnt;
      logic [UW-1:0] uv_cnt;
      logic rst_n_out;
   } spc_rg_s;

   spc_rg_s st_ff;
   spc_rg_s nxt_st;

   // Power-on delay, then watch for filtered undervoltage
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rst_n_out = 1'b0;
      case (st_ff.state)
         RG_HOLD: begin
            nxt_st.cnt = '0;
            if (por_ok && !hold) begin
               nxt_st.state = RG_DELAY;
            end
         end
         RG_DELAY: begin
            // Supply dip during the delay restarts it [RL12]
            if (!por_ok || hold) begin
               nxt_st.state = RG_HOLD;
            end else if (st_ff.cnt == CW'(POR_CYC - 1)) begin
               nxt_st.state = RG_RUN;
               nxt_st.rst_n_out = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt + 1'b1;
            end
         end
         RG_RUN: begin
            nxt_st.rst_n_out = 1'b1;
            nxt_st.uv_cnt = uv_low ? st_ff.uv_cnt + 1'b1 : '0;
            // Trip on hold, or once low for the full filter time [RL13]
            if (hold || st_ff.uv_cnt == UW'(UV_CYC)) begin
               nxt_st.state = RG_HOLD;
               nxt_st.uv_cnt = '0;
               nxt_st.rst_n_out = 1'b0;
            end
         end
         default: begin
            nxt_st.state = RG_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{RG_HOLD, '0, '0, 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mcu_reset_n = st_ff.rst_n_out;

endmodule

// *** core/spc_top.sv ***
// Notes on behaviour
// RL1: Sample serial input on clock rise in frame
// RL2: Output changes on clock fall; master samples rise
// RL3: Chip select high: ignore clock, output released
// RL4: Each frame carries exactly sixteen clock pulses
// RL5: Wrong pulse count sets interface error flag
// RL6: Invalid sixteen-bit message also sets error
// RL7: Select fall: drive output, load status word
// RL8: Select rise: release output, apply command
// RL9: Master moves select only with clock low
// RL10: Both words MSB first through one FIFO shifter
// RL11: Fault bits read one, healthy read zero
// RL12: Reset held for fixed delay after power-on
// RL13: Filtered undervoltage asserts reset until power-on
// RL14: Sensor supply follows its control bit
// RL15: Sleep when key low and hold bit low
// RL16: Key low with hold: outputs off, relay exception
// RL17: Only hold bit governs shutdown; zero sleeps
// RL18: Key high wakes, enables pre-regulator, resets MCU
// RL19: Key state readable in status word
// RL20: Battery switch follows key by default
// RL21: Battery switch state readable in status
// RL22: Mode bit: follow key or PWM high side
// RL23: Relay two stays on with hold and disable
// RL24: Bit counter cleared at each select fall
// RL25: Key input synchronised before any use
module spc_top
   import spc_pkg::*;
#(
   parameter int POR_CYC = POR_CYCLES,
   parameter int UV_CYC = UV_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic key_switch_in,
   input wire logic relay_two_input,
   input wire logic vcc_por_ok,
   input wire logic vcc_uv_low,
   input wire logic [FAULT_BITS-1:0] driver_fault,
   output logic mcu_reset_n,
   output logic sensor_supply_en,
   output logic preregulator_en,
   output logic sleep_mode,
   output logic battery_switch_out,
   output logic relay_two_output,
   output logic spi_error
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic sclk_q;
      logic cs_n_q;
      logic key_q;
      logic [WORD_BITS-1:0] shreg;
      logic [4:0] pulses;
      logic so;
      logic so_oe;
      logic err;
      logic [7:0] ctl;
      logic [7:0] bsw_cfg;
      logic [7:0] r2_cfg;
      logic [PWM_BITS-1:0] pwm_cnt;
      logic bsw;
      logic r2;
      logic sensor_supply;
      logic prereg;
      logic sleep;
   } spc_top_s;

   spc_top_s st_ff;
   spc_top_s nxt_st;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Edge of a synchronised level against its copy
   function automatic logic rose(input logic now, input logic was);
      rose = now & ~was;
   endfunction

   function automatic logic fell(input logic now, input logic was);
      fell = ~now & was;
   endfunction

   // Known target and reserved bits clear
   function automatic logic cmd_ok(input logic [WORD_BITS-1:0] w);
      logic known;
      case (w[ADDR_MSB:ADDR_LSB])
         ADDR_STATUS: known = 1'b1;
         ADDR_CONTROL: known = 1'b1;
         ADDR_BSW_CFG: known = 1'b1;
         ADDR_R2_CFG: known = 1'b1;
         default: known = 1'b0;
      endcase
      // Reserved nibble must be zero
      cmd_ok = known && (w[RSVD_MSB:RSVD_LSB] == 4'h0);
   endfunction

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   localparam int SW = 7 + FAULT_BITS;
   // Flush value matches each pin's idle level,
   // so no false select edge follows reset
   localparam logic [SW-1:0] SYNC_IDLE = {
      1'b0, // Serial clock idles low
      1'b1, // Select idles high, deselected
      1'b0,
      1'b0,
      1'b0,
      1'b0,
      1'b0,
      {FAULT_BITS{1'b0}}
   };

   logic [SW-1:0] raw;
   logic [SW-1:0] syn;

   // All pins are asynchronous to clk [RL25]
   assign raw = {
      sclk,
      chip_select_n,
      serial_in,
      key_switch_in,
      relay_two_input,
      vcc_por_ok,
      vcc_uv_low,
      driver_fault
   };

   spc_sync #(
      .W(SW),
      .RST_VAL(SYNC_IDLE)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(raw),
      .q(syn)
   );

   logic sclk_s;
   logic cs_n_s;
   logic si_s;
   logic key_s;
   logic relay_two_input_s;
   logic por_ok_s;
   logic uv_low_s;
   logic [FAULT_BITS-1:0] fault_s;

   assign sclk_s = syn[SW-1];
   assign cs_n_s = syn[SW-2];
   assign si_s = syn[SW-3];
   assign key_s = syn[SW-4];
   assign relay_two_input_s = syn[SW-5];
   assign por_ok_s = syn[SW-6];
   assign uv_low_s = syn[SW-7];
   assign fault_s = syn[FAULT_BITS-1:0];

   // ---------------------------------------------
   // MCU reset generator
   // ---------------------------------------------
   // Held in reset while asleep; wake restarts delay [RL18]
   spc_reset_gen #(
      .POR_CYC(POR_CYC),
      .UV_CYC(UV_CYC)
   ) u_rst (
      .clk(clk),
      .rst_n(rst_n),
      .hold(st_ff.sleep),
      .por_ok(por_ok_s),
      .uv_low(uv_low_s),
      .mcu_reset_n(mcu_reset_n)
   );

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic in_frame;
   logic [WORD_BITS-1:0] status;
   logic [WORD_BITS-1:0] cmd;
   logic good;
   logic hold;
   logic pwm_on;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_q = sclk_s;
      nxt_st.cs_n_q = cs_n_s;
      nxt_st.key_q = key_s;

      // ------------------------------------------
      // Serial link
      // ------------------------------------------
      // Edges only count while selected [RL3]
      // Both samples low, so the select edge itself never counts
      in_frame = ~cs_n_s & ~st_ff.cs_n_q;
      sclk_rise = in_frame & rose(sclk_s, st_ff.sclk_q);
      sclk_fall = in_frame & fell(sclk_s, st_ff.sclk_q);
      cs_fall = fell(cs_n_s, st_ff.cs_n_q);
      cs_rise = rose(cs_n_s, st_ff.cs_n_q);

      // Status snapshot: faults read as one [RL11]
      status = '0;
      status[ST_SPI_ERR] = st_ff.err;
      status[ST_KEY] = key_s; // [RL19]
      status[ST_BSW] = st_ff.bsw; // [RL21]
      status[ST_POWER_HOLD] = st_ff.ctl[CTL_POWER_HOLD];
      status[FAULT_BITS-1:0] = fault_s; // [RL11]

      // Judged on the word as it stands at the select rise
      cmd = st_ff.shreg;
      good = (st_ff.pulses == FRAME_PULSES) && cmd_ok(cmd);

      // Frame start: drive output, load status [RL7]
      if (cs_fall) begin
         nxt_st.shreg = status; // [RL7]
         nxt_st.so = status[WORD_BITS-1]; // [RL10]
         nxt_st.so_oe = 1'b1; // [RL7]
         nxt_st.pulses = '0; // [RL24]
         // Error reported once, then cleared
         nxt_st.err = 1'b0;
      end

      // Shift in at LSB on rise [RL1]
      if (sclk_rise) begin
         nxt_st.shreg = {st_ff.shreg[WORD_BITS-2:0], si_s}; // [RL10]
         // Saturate so long frames never wrap to sixteen
         if (st_ff.pulses != 5'h1f) begin
            nxt_st.pulses = st_ff.pulses + 1'b1;
         end
      end

      // Present next MSB on fall [RL2]
      if (sclk_fall) begin
         nxt_st.so = st_ff.shreg[WORD_BITS-1]; // [RL2]
      end

      // Frame end: release output, act on command [RL8]
      if (cs_rise) begin
         nxt_st.so_oe = 1'b0; // [RL8]
         nxt_st.so = 1'b0;
         if (!good) begin
            nxt_st.err = 1'b1; // [RL5] [RL6]
         end else begin
            // Only complete sixteen-pulse words apply [RL4]
            case (cmd[ADDR_MSB:ADDR_LSB])
               ADDR_CONTROL: nxt_st.ctl = cmd[DATA_MSB:0];
               ADDR_BSW_CFG: nxt_st.bsw_cfg = cmd[DATA_MSB:0];
               ADDR_R2_CFG: nxt_st.r2_cfg = cmd[DATA_MSB:0];
               default: nxt_st.ctl = st_ff.ctl;
            endcase
         end
      end

      // ------------------------------------------
      // Power sequencing
      // ------------------------------------------
      hold = st_ff.ctl[CTL_POWER_HOLD]; // [RL17]
      // Sleep needs both key and hold low [RL15]
      nxt_st.sleep = ~key_s & ~hold; // [RL15] [RL17]
      // Key rising wakes at once [RL18]
      if (rose(key_s, st_ff.key_q)) begin
         nxt_st.sleep = 1'b0; // [RL18]
      end
      // Pre-regulator follows the awake state [RL18]
      nxt_st.prereg = ~nxt_st.sleep;

      // Sensor supply under its own bit [RL14]
      // Gated by the next sleep value so it never lags into sleep
      nxt_st.sensor_supply = st_ff.ctl[CTL_SENSOR_SUPPLY] & ~nxt_st.sleep;

      // ------------------------------------------
      // Battery switch and relay two
      // ------------------------------------------
      // PWM for the high side mode
      nxt_st.pwm_cnt = st_ff.pwm_cnt + 1'b1;
      pwm_on = st_ff.pwm_cnt < st_ff.bsw_cfg[BSW_DUTY_LSB +: PWM_BITS];

      // Battery switch mode select [RL22]
      if (st_ff.bsw_cfg[BSW_HS_MODE]) begin
         nxt_st.bsw = st_ff.ctl[CTL_HS_ON] & pwm_on & key_s; // [RL22] [RL16]
      end else begin
         nxt_st.bsw = key_s; // [RL20]
      end

      // Relay two: pin OR bit; key low turns it off unless hold and SDD are set [RL16]
      nxt_st.r2 = (relay_two_input_s | st_ff.ctl[CTL_RELAY_TWO]) &
                  (key_s | (hold & st_ff.r2_cfg[R2_SDD])); // [RL16] [RL23]
      // Same cycle as entering sleep, no stray on-cycle [RL15]
      if (nxt_st.sleep) begin
         nxt_st.r2 = 1'b0;
         nxt_st.bsw = 1'b0;
      end
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   // Select and clock idle high/low after reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '{
            sclk_q: 1'b0,
            cs_n_q: 1'b1,
            key_q: 1'b0,
            shreg: '0,
            pulses: '0,
            so: 1'b0,
            so_oe: 1'b0,
            err: 1'b0,
            ctl: CTL_RESET,
            bsw_cfg: BSW_CFG_RESET,
            r2_cfg: R2_CFG_RESET,
            pwm_cnt: '0,
            bsw: 1'b0,
            r2: 1'b0,
            sensor_supply: 1'b0,
            prereg: 1'b0,
            sleep: 1'b1
         };
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign serial_out = st_ff.so;
   assign serial_out_oe = st_ff.so_oe; // [RL3]
   assign sensor_supply_en = st_ff.sensor_supply;
   assign preregulator_en = st_ff.prereg;
   assign sleep_mode = st_ff.sleep;
   assign battery_switch_out = st_ff.bsw;
   assign relay_two_output = st_ff.r2;
   assign spi_error = st_ff.err;

endmodule

// *** verif/spc_top_monitor.sv ***
module spc_top_monitor
   import spc_pkg::*;
#(
   parameter int POR_CYC = POR_CYCLES,
   parameter int UV_CYC = UV_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic key_switch_in,
   input wire logic vcc_por_ok,
   input wire logic vcc_uv_low,
   input wire logic mcu_reset_n,
   input wire logic sensor_supply_en,
   input wire logic preregulator_en,
   input wire logic sleep_mode,
   input wire logic relay_two_output,
   input wire logic spi_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [4:0] pulses_ff;
   int por_ff;
   int uv_ff;
   // ---------------------------------------------
   // Pin-level counters
   // ---------------------------------------------
   // Counted at the pins, so sync latency adds margin to a_por_hold but uses up part of the slack in a_uv_reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulses_ff <= 5'h00;
         por_ff <= 0;
         uv_ff <= 0;
      end else begin
         if ($fell(chip_select_n)) begin
            pulses_ff <= 5'h00;
         end else if (!chip_select_n && $rose(sclk) && pulses_ff != 5'h1f) begin
            pulses_ff <= pulses_ff + 5'h01;
         end
         por_ff <= (vcc_por_ok && !vcc_uv_low && !sleep_mode) ? por_ff + int'(por_ff < POR_CYC + 9) : 0;
         uv_ff <= vcc_uv_low ? uv_ff + int'(uv_ff < UV_CYC + 9) : 0;
      end
   end
   a_oe_on: assert property (
      $fell(chip_select_n) |-> ##[3:4] serial_out_oe) else $error("output not enabled after select fall");
   a_oe_off: assert property (
      $rose(chip_select_n) |-> ##[3:4] !serial_out_oe) else $error("output still driven after select rise");
   a_out_idle: assert property (
      !serial_out_oe |-> !serial_out) else $error("output data while released");
   a_out_stable: assert property (
      serial_out_oe && sclk && $past(sclk) |-> $stable(serial_out)) else $error("output moved in high phase");
   a_len_error: assert property (
      $rose(chip_select_n) && pulses_ff != FRAME_PULSES |-> ##[3:6] spi_error) else $error("bad length not flagged");
   a_key_wake: assert property (
      $rose(key_switch_in) |-> ##[2:6] !sleep_mode) else $error("no wake on key rise");
   a_sleep_outs: assert property (
      sleep_mode |-> !preregulator_en && !sensor_supply_en && !relay_two_output) else $error("output on in sleep");
   a_sleep_reset: assert property (
      sleep_mode && $past(sleep_mode) |-> !mcu_reset_n) else $error("reset released in sleep");
   a_uv_reset: assert property (
      uv_ff == UV_CYC + 6 |-> !mcu_reset_n) else $error("undervoltage did not reset");
   a_por_hold: assert property (
      $rose(mcu_reset_n) |-> por_ff >= POR_CYC - 2) else $error("reset released too early");
endmodule

bind spc_top spc_top_monitor #(.POR_CYC(POR_CYC), .UV_CYC(UV_CYC)) mon (.clk(clk), .rst_n(rst_n), .sclk(sclk),
   .chip_select_n(chip_select_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
   .key_switch_in(key_switch_in), .vcc_por_ok(vcc_por_ok), .vcc_uv_low(vcc_uv_low), .mcu_reset_n(mcu_reset_n),
   .sensor_supply_en(sensor_supply_en), .preregulator_en(preregulator_en), .sleep_mode(sleep_mode),
   .relay_two_output(relay_two_output), .spi_error(spi_error));

// *** verif/spc_spi_master.sv ***
module spc_spi_master (
   input wire logic clk,
   output logic sclk,
   output logic chip_select_n,
   output logic serial_in,
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands low between frames; select idles at its pull-up
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One frame of n pulses, 4 clk per phase, word MSB first
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk);
      chip_select_n <= 1'b0;
      pause(8);
      for (int i = 0; i < n; i++) begin
         serial_in <= w[15 - (i % 16)];
         pause(4);
         sclk <= 1'b1;
         pause(4);
         rx = {rx[14:0], serial_out};
         sclk <= 1'b0;
      end
      pause(4);
      chip_select_n <= 1'b1;
      serial_in <= ~serial_in; // Released line does not keep last bit
      pause(8);
   endtask
endmodule

// *** verif/spi_slave_power_control_tb_top.sv ***
module spi_slave_power_control_tb_top
   import spc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR_T = 20;
   localparam int UV_T = 5;
   logic clk, rst_n, key, por_ok, uv_low, relay_in;
   logic [7:0] fault;
   logic [15:0] rx, hi;
   wire logic sclk, cs_n, sdi, sdo, sdo_oe, mrst_n, sens, prereg, sleep, bsw, relay, err;
   int failures;
   int tests_run;
   logic [15:0] bad_w [4] = '{16'h1000, 16'h1000, 16'h5000, 16'h1103};
   int bad_n [4] = '{15, 17, 16, 16};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   spc_top #(.POR_CYC(POR_T), .UV_CYC(UV_T)) uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(cs_n),
      .serial_in(sdi), .serial_out(sdo), .serial_out_oe(sdo_oe), .key_switch_in(key), .relay_two_input(relay_in),
      .vcc_por_ok(por_ok), .vcc_uv_low(uv_low), .driver_fault(fault), .mcu_reset_n(mrst_n),
      .sensor_supply_en(sens), .preregulator_en(prereg), .sleep_mode(sleep), .battery_switch_out(bsw),
      .relay_two_output(relay), .spi_error(err));
   spc_spi_master m (.clk(clk), .sclk(sclk), .chip_select_n(cs_n), .serial_in(sdi), .serial_out(sdo));
   // ---------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      m.xfer({a, 4'h0, d}, 16, rx);
   endtask
   task automatic wait_rst;
      for (int i = 0; i < 200 && mrst_n !== 1'b1; i++) @(posedge clk);
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Guard against a hang; tests need well under 10k cycles
   initial begin
      gap(30000);
      failures++;
      $display("CHECK FAILED watchdog expected done seen hang");
      results();
   end
   initial begin
      {rst_n, uv_low, relay_in} = 3'b000;
      {key, por_ok} = 2'b11;
      fault = 8'ha5;
      gap(10);
      rst_n <= 1'b1;
      wait_rst();
      chk("reset release", 1, mrst_n);
      m.xfer(16'h0000, 16, rx);
      chk("status", 16'h60a5, rx);
      chk("oe after frame", 0, sdo_oe);
      wr(ADDR_CONTROL, 8'h03);
      chk("sensor supply", 1, sens);
      $display("Test basic done");
      // Refused frames must leave control untouched
      for (int i = 0; i < 4; i++) begin
         m.xfer(bad_w[i], bad_n[i], rx);
         chk("error flag", 1, err);
         m.xfer(16'h0000, 16, rx);
         chk("status error", 16'hf0a5, rx);
         chk("error cleared", 0, err);
         chk("sensor kept", 1, sens);
      end
      $display("Test bad frames done");
      wr(ADDR_CONTROL, 8'h0b);
      wr(ADDR_BSW_CFG, 8'h01);
      chk("high side duty 0", 0, bsw);
      wr(ADDR_BSW_CFG, 8'hf1);
      hi = 16'h0000;
      // Sampled mid-cycle, clear of the edge that moves the output
      repeat (16) begin
         @(negedge clk);
         hi = hi + bsw;
      end
      chk("high side duty 15", 15, hi);
      wr(ADDR_BSW_CFG, 8'h00);
      chk("follow key", 1, bsw);
      relay_in <= 1'b1;
      gap(6);
      chk("relay pin", 1, relay);
      relay_in <= 1'b0;
      $display("Test battery switch done");
      wr(ADDR_R2_CFG, 8'h01);
      wr(ADDR_CONTROL, 8'h07);
      key <= 1'b0;
      gap(8);
      chk("held awake", 0, sleep);
      chk("bsw off", 0, bsw);
      chk("relay kept", 1, relay);
      fault <= 8'h5a;
      m.xfer(16'h0000, 16, rx);
      chk("status key low", 16'h105a, rx);
      wr(ADDR_R2_CFG, 8'h00);
      chk("relay off", 0, relay);
      wr(ADDR_CONTROL, 8'h00);
      chk("sleep", 1, sleep);
      chk("prereg off", 0, prereg);
      chk("reset in sleep", 0, mrst_n);
      key <= 1'b1;
      gap(8);
      chk("woken", 0, sleep);
      chk("prereg on", 1, prereg);
      chk("wake reset", 0, mrst_n);
      wait_rst();
      chk("wake release", 1, mrst_n);
      $display("Test key and sleep done");
      // Short dip is filtered, long one resets
      uv_low <= 1'b1;
      gap(3);
      uv_low <= 1'b0;
      gap(10);
      chk("uv filtered", 1, mrst_n);
      uv_low <= 1'b1;
      gap(20);
      chk("uv reset", 0, mrst_n);
      // Supply also below power-on: delay must not start yet
      uv_low <= 1'b0;
      por_ok <= 1'b0;
      gap(30);
      chk("uv held", 0, mrst_n);
      por_ok <= 1'b1;
      gap(4);
      chk("por delay", 0, mrst_n);
      wait_rst();
      chk("uv release", 1, mrst_n);
      $display("Test undervoltage done");
      results();
   end
endmodule
